// ==== hw/dpg_regs.svh ====
// Register offsets, field positions, reset values for the debug port group
`ifndef DPG_REGS_SVH
`define DPG_REGS_SVH
`define DPG_OFS_DATA 12'h000
`define DPG_OFS_IOEN 12'h004
`define DPG_OFS_PULL 12'h008
`define DPG_OFS_INTF 12'h00c
`define DPG_OFS_MODE 12'h010
`define DPG_OFS_FUNC 12'h014
`define DPG_HI_LSB 8
`define DPG_MODE_RST 5'h07
`define DPG_FUNC_DEBUG 2'h0
`define DPG_FUNC_OSC 2'h2
`define DPG_INTF_VAL 16'h0000
`define DPG_OUT_ONLY_PIN 2
`endif

// ==== hw/dpg_pkg.sv ====
// Types for the debug port group
package dpg_pkg;
    typedef logic [4:0] dpg_pins_t;
    typedef logic [1:0] dpg_func_t;
endpackage

// ==== hw/dpg_gpio.sv ====
// Five-pin debug port group: GPIO and alternate functions with APB registers
//
// How it works
// - Pins 0 to 2 start in peripheral mode carrying the debug link.
// - Every pin in GPIO mode has a writable output latch; all but pin 2 have readable input.
// - Pin 2 is output only as GPIO; its input enable is absent, input reads zero.
// - Pin 2 has no pull resistor; its pull bits are inert.
// - Mode bit picks GPIO or function field; bits 0-2 reset 1, 3-4 reset 0.
// - Function 0 gives debug status, data, clock; function 2 gives oscillator.
// - No interrupt; flag register reads zero, no filter or interrupt control.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "dpg_regs.svh"

module dpg_gpio
    import dpg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [4:0] pin_in_i,
    output logic [4:0] pin_out_o,
    output logic [4:0] pin_oe_o,
    output logic [4:0] pin_pull_en_o,
    output logic [4:0] pin_pull_up_o,
    output logic debug_status_pin_o,
    output logic debug_clock_pin_o,
    output logic debug_serial_data_o,
    output logic debug_serial_data_oe_o,
    input wire logic debug_serial_data_i,
    input wire logic debug_status_pin_oe_i,
    input wire logic debug_clock_pin_i,
    input wire logic oscillator_out_pin_i,
    input wire logic oscillator_out_oe_i,
    output logic oscillator_in_pin_o
);
    dpg_pins_t pin_output_latch_r;
    dpg_pins_t pin_input_enable_r;
    dpg_pins_t pin_output_enable_r;
    dpg_pins_t pin_pull_direction_r;
    dpg_pins_t pin_pull_enable_r;
    dpg_pins_t pin_peripheral_mode_r;
    logic [9:0] pin_function_field_r;
    dpg_pins_t pin_input_value;
    logic wr_en;
    logic [31:0] rdata_nxt;
    logic hit;
    localparam dpg_pins_t PIN_MASK = 5'h1b; // Pins with an input path and pulls

    // Zero-wait APB slave
    assign pready_o = 1'b1;
    assign wr_en = psel_i & penable_i & pwrite_i;

    // Output latch, written through the data register
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_output_latch_r <= 5'h00;
        end else if (wr_en && (paddr_i == `DPG_OFS_DATA)) begin
            pin_output_latch_r <= pwdata_i[`DPG_HI_LSB +: 5];
        end
    end

    // Input enables; pin 2 has no GPIO input path so its bit stays zero
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_input_enable_r <= 5'h00;
        end else if (wr_en && (paddr_i == `DPG_OFS_IOEN)) begin
            pin_input_enable_r <= pwdata_i[`DPG_HI_LSB +: 5] & PIN_MASK;
        end
    end

    // Output enables, all five pins
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_output_enable_r <= 5'h00;
        end else if (wr_en && (paddr_i == `DPG_OFS_IOEN)) begin
            pin_output_enable_r <= pwdata_i[4:0];
        end
    end

    // Pull direction; pin 2 bit inert
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_pull_direction_r <= 5'h00;
        end else if (wr_en && (paddr_i == `DPG_OFS_PULL)) begin
            pin_pull_direction_r <= pwdata_i[`DPG_HI_LSB +: 5] & PIN_MASK;
        end
    end

    // Pull enable; pin 2 bit inert
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_pull_enable_r <= 5'h00;
        end else if (wr_en && (paddr_i == `DPG_OFS_PULL)) begin
            pin_pull_enable_r <= pwdata_i[4:0] & PIN_MASK;
        end
    end

    // Mode bits; debug pins come up in peripheral mode
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_peripheral_mode_r <= `DPG_MODE_RST;
        end else if (wr_en && (paddr_i == `DPG_OFS_MODE)) begin
            pin_peripheral_mode_r <= pwdata_i[4:0];
        end
    end

    // Function fields, two bits per pin
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_function_field_r <= 10'h000;
        end else if (wr_en && (paddr_i == `DPG_OFS_FUNC)) begin
            pin_function_field_r <= pwdata_i[9:0];
        end
    end

    // Input path gated by input enable, GPIO mode only
    assign pin_input_value = pin_in_i & pin_input_enable_r & ~pin_peripheral_mode_r
        & PIN_MASK;

    // Read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit = 1'b1;
        case (paddr_i)
            `DPG_OFS_DATA: rdata_nxt = {19'h0, pin_output_latch_r, 3'h0,
                pin_input_value};
            `DPG_OFS_IOEN: rdata_nxt = {19'h0, pin_input_enable_r, 3'h0,
                pin_output_enable_r};
            `DPG_OFS_PULL: rdata_nxt = {19'h0, pin_pull_direction_r, 3'h0,
                pin_pull_enable_r};
            `DPG_OFS_INTF: rdata_nxt = {16'h0, `DPG_INTF_VAL};
            `DPG_OFS_MODE: rdata_nxt = {27'h0, pin_peripheral_mode_r};
            `DPG_OFS_FUNC: rdata_nxt = {22'h0, pin_function_field_r};
            default: hit = 1'b0;
        endcase
    end
    assign prdata_o = rdata_nxt;
    assign pslverr_o = psel_i & penable_i & ~hit;

    // Per-pin pad drive, GPIO or peripheral
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_pin
            dpg_func_t fn;
            logic per_out;
            logic per_oe;
            assign fn = pin_function_field_r[2*g +: 2];
            always_comb begin
                per_out = 1'b0;
                per_oe = 1'b0;
                case (g)
                    0: begin
                        per_out = 1'b0;
                        per_oe = (fn == `DPG_FUNC_DEBUG) & debug_status_pin_oe_i;
                    end
                    1: begin
                        per_out = 1'b0;
                        per_oe = 1'b0;
                    end
                    2: begin
                        per_out = 1'b0;
                        per_oe = 1'b0;
                    end
                    4: begin
                        per_out = oscillator_out_pin_i;
                        per_oe = (fn == `DPG_FUNC_OSC) & oscillator_out_oe_i;
                    end
                    default: begin
                    end
                endcase
            end
            // Drive only with output enable in GPIO mode
            assign pin_out_o[g] = pin_peripheral_mode_r[g] ? per_out
                : pin_output_latch_r[g];
            assign pin_oe_o[g] = pin_peripheral_mode_r[g] ? per_oe
                : pin_output_enable_r[g];
            assign pin_pull_en_o[g] = pin_pull_enable_r[g] & PIN_MASK[g];
            assign pin_pull_up_o[g] = pin_pull_direction_r[g] & PIN_MASK[g];
        end
    endgenerate

    // Debug link signals into and out of the pads
    logic dbg0_sel;
    logic dbg1_sel;
    logic dbg2_sel;
    logic osc_sel;
    assign dbg0_sel = pin_peripheral_mode_r[0] & (pin_function_field_r[1:0] == `DPG_FUNC_DEBUG);
    assign dbg1_sel = pin_peripheral_mode_r[1] & (pin_function_field_r[3:2] == `DPG_FUNC_DEBUG);
    assign dbg2_sel = pin_peripheral_mode_r[2] & (pin_function_field_r[5:4] == `DPG_FUNC_DEBUG);
    assign osc_sel = pin_peripheral_mode_r[3] & (pin_function_field_r[7:6] == `DPG_FUNC_OSC);
    assign debug_status_pin_o = dbg0_sel & pin_in_i[0];
    assign debug_serial_data_o = dbg1_sel & pin_in_i[1];
    assign debug_clock_pin_o = dbg2_sel & pin_in_i[2];
    assign oscillator_in_pin_o = osc_sel & pin_in_i[3];
    assign debug_serial_data_oe_o = dbg1_sel;

    logic unused_ok;
    assign unused_ok = debug_serial_data_i ^ debug_clock_pin_i;

    // Checks
    chk_reset_mode: assert property (@(posedge core_clk_i)
        srst_i |=> pin_peripheral_mode_r == 5'h07)
        else $error("mode bits wrong after reset");
    chk_pin2_in_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pin_input_value[2] == 1'b0)
        else $error("pin 2 input not zero");
    chk_pin2_no_pull: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pin_pull_en_o[2] && !pin_pull_up_o[2])
        else $error("pin 2 pull active");
    chk_intf_zero: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (paddr_i == `DPG_OFS_INTF) |-> prdata_o == 32'h0)
        else $error("interrupt flag not zero");
    chk_gpio_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pin_peripheral_mode_r[3] |-> pin_oe_o[3] == pin_output_enable_r[3])
        else $error("gpio drive mismatch");
    chk_latch_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (wr_en && paddr_i == `DPG_OFS_DATA) |=> pin_out_o[0] == pin_output_latch_r[0]
        && pin_output_latch_r == $past(pwdata_i[12:8]))
        else $error("output latch not written");
    chk_mode_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (wr_en && paddr_i == `DPG_OFS_MODE)
        |=> pin_peripheral_mode_r == $past(pwdata_i[4:0]))
        else $error("mode not written");
    chk_dbg_route: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dbg2_sel |-> debug_clock_pin_o == pin_in_i[2])
        else $error("debug clock not routed");

    // Bus steps: enable, pull, function and GPIO-mode writes, and an unmapped access
    sequence s_wr_ioen;
        wr_en && (paddr_i == `DPG_OFS_IOEN);
    endsequence
    sequence s_wr_pull;
        wr_en && (paddr_i == `DPG_OFS_PULL);
    endsequence
    sequence s_wr_func;
        wr_en && (paddr_i == `DPG_OFS_FUNC);
    endsequence
    sequence s_wr_mode_gpio;
        wr_en && (paddr_i == `DPG_OFS_MODE) && (pwdata_i[4:0] == 5'h00);
    endsequence
    sequence s_unmapped_access;
        psel_i && penable_i && (paddr_i > `DPG_OFS_FUNC);
    endsequence

    // Reset state of the function, latch and enable registers and the debug data route
    chk_reset_func: assert property (@(posedge core_clk_i)
        srst_i |=> pin_function_field_r == 10'h000)
        else $error("function fields wrong after reset");
    chk_reset_gpio: assert property (@(posedge core_clk_i)
        srst_i |=> (pin_output_latch_r == 5'h00) && (pin_output_enable_r == 5'h00)
        && (pin_input_enable_r == 5'h00))
        else $error("gpio registers wrong after reset");
    chk_reset_route: assert property (@(posedge core_clk_i)
        srst_i |=> debug_serial_data_oe_o)
        else $error("debug data not routed after reset");

    // Register writes land one cycle after the access
    chk_ien_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_wr_ioen |=> (pin_input_enable_r == ($past(pwdata_i[12:8]) & PIN_MASK))
        && (pin_output_enable_r == $past(pwdata_i[4:0])))
        else $error("enable register not written");
    chk_pull_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_wr_pull |=> (pin_pull_direction_r == ($past(pwdata_i[12:8]) & PIN_MASK))
        && (pin_pull_enable_r == ($past(pwdata_i[4:0]) & PIN_MASK)))
        else $error("pull register not written");
    chk_func_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_wr_func |=> pin_function_field_r == $past(pwdata_i[9:0]))
        else $error("function fields not written");
    chk_mode_gpio: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_wr_mode_gpio |=> (pin_oe_o == pin_output_enable_r)
        && (pin_out_o == pin_output_latch_r))
        else $error("gpio mode not taking the pads");

    // Pin 2 keeps no input enable and drives only as GPIO
    chk_pin2_no_ien: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pin_input_enable_r[2] == 1'b0)
        else $error("pin 2 input enable set");
    chk_pin2_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pin_peripheral_mode_r[2] |-> (pin_oe_o[2] == pin_output_enable_r[2])
        && (pin_out_o[2] == pin_output_latch_r[2]))
        else $error("pin 2 gpio drive wrong");

    // GPIO input and output paths
    chk_gpio_input: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (!pin_peripheral_mode_r[0] && pin_input_enable_r[0])
        |-> pin_input_value[0] == pin_in_i[0])
        else $error("gpio input not seen");
    chk_input_gated: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pin_input_enable_r[1] |-> !pin_input_value[1])
        else $error("disabled input not zero");
    chk_periph_no_in: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pin_peripheral_mode_r[3] |-> !pin_input_value[3])
        else $error("input seen in peripheral mode");
    chk_gpio_out: assert property (@(posedge core_clk_i) disable iff (srst_i)
        !pin_peripheral_mode_r[4] |-> (pin_out_o[4] == pin_output_latch_r[4])
        && (pin_oe_o[4] == pin_output_enable_r[4]))
        else $error("gpio output not driven from latch");

    // Peripheral routing of the debug and oscillator pins
    chk_osc_drive: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (pin_peripheral_mode_r[4] && (pin_function_field_r[9:8] == `DPG_FUNC_OSC))
        |-> (pin_oe_o[4] == oscillator_out_oe_i)
        && (pin_out_o[4] == oscillator_out_pin_i))
        else $error("oscillator output not routed");
    chk_osc_input: assert property (@(posedge core_clk_i) disable iff (srst_i)
        osc_sel |-> oscillator_in_pin_o == pin_in_i[3])
        else $error("oscillator input not routed");
    chk_status_route: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dbg0_sel |-> debug_status_pin_o == pin_in_i[0])
        else $error("debug status not routed");
    chk_data_route: assert property (@(posedge core_clk_i) disable iff (srst_i)
        dbg1_sel |-> (debug_serial_data_o == pin_in_i[1]) && debug_serial_data_oe_o)
        else $error("debug data not routed");
    chk_periph_quiet: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pin_peripheral_mode_r[1] |-> !pin_oe_o[1])
        else $error("pin 1 driven in peripheral mode");

    // Bus answers: never waits, flags unmapped accesses
    chk_ready_high: assert property (@(posedge core_clk_i) disable iff (srst_i)
        pready_o)
        else $error("ready not high");
    chk_unmapped_err: assert property (@(posedge core_clk_i) disable iff (srst_i)
        s_unmapped_access |-> pslverr_o && (prdata_o == 32'h0000_0000))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (@(posedge core_clk_i) disable iff (srst_i)
        (psel_i && penable_i && (paddr_i == `DPG_OFS_INTF)) |-> !pslverr_o)
        else $error("flag register access refused");
endmodule

// ==== tb/dpg_pad_model.sv ====
// Pad model for the five pins: block, outside source, pull, float
`timescale 1ns/1ps
module dpg_pad_model (
    input wire logic core_clk_i,
    input wire logic [4:0] pin_out_i,
    input wire logic [4:0] pin_oe_i,
    input wire logic [4:0] pull_en_i,
    input wire logic [4:0] pull_up_i,
    input wire logic [4:0] ext_val_i,
    input wire logic [4:0] ext_en_i,
    output logic [4:0] pad_o
);
    logic [4:0] last_r = 5'h00;
    // Resolve each pad level in priority order
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pad_o[i] = pin_oe_i[i] ? pin_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                pull_en_i[i] ? pull_up_i[i] : ~last_r[i];
        end
    end
    // Undriven pad toggles each cycle
    always_ff @(posedge core_clk_i) begin
        last_r <= pad_o;
    end
endmodule

// ==== tb/dpg_gpio_tb.sv ====
// Self-checking bench for the debug port group
`timescale 1ns/1ps
`include "dpg_regs.svh"
module dpg_gpio_tb;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, dso, dsoe, dst, dck, osci;
    logic sts_oe, osc_o, osc_oe;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, v, seed, ex;
    logic [4:0] pout, poe, pen, pup, pad, xval, xen, oen, ien, lat;
    int err_count, comparisons;
    logic [31:0] exp_q[$];
    dpg_gpio dpg_gpio_i (.core_clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pin_in_i(pad), .pin_out_o(pout),
        .pin_oe_o(poe), .pin_pull_en_o(pen), .pin_pull_up_o(pup), .debug_status_pin_o(dst),
        .debug_clock_pin_o(dck), .debug_serial_data_o(dso), .debug_serial_data_oe_o(dsoe),
        .debug_serial_data_i(1'b0), .debug_status_pin_oe_i(sts_oe), .debug_clock_pin_i(1'b0),
        .oscillator_out_pin_i(osc_o), .oscillator_out_oe_i(osc_oe), .oscillator_in_pin_o(osci));
    dpg_pad_model dpg_pad_model_i (.core_clk_i(clk), .pin_out_i(pout), .pin_oe_i(poe),
        .pull_en_i(pen), .pull_up_i(pup), .ext_val_i(xval), .ext_en_i(xen), .pad_o(pad));
    // Clock, 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // One APB transfer; a read notes its expected data
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_q.push_back(d);
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // Read data checked at the completing edge
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) chk(exp_q.pop_front(), prdata);
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {srst, xval, xen, sts_oe, osc_o, osc_oe} = {1'b1, 5'h06, 5'h1f, 3'h0};
        {seed, err_count, comparisons} = {32'h050a813f, 64'h0};
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(32'he, {28'h0, dsoe, dso, dck, dst});
        apb(0, `DPG_OFS_MODE, 32'h7);
        apb(0, `DPG_OFS_FUNC, 32'h0);
        apb(1, `DPG_OFS_INTF, 32'hffff);
        apb(0, `DPG_OFS_INTF, 32'h0);
        apb(1, `DPG_OFS_PULL, 32'hffff);
        apb(0, `DPG_OFS_PULL, 32'h1b1b);
        chk(32'h1b, {27'h0, pen});
        apb(0, 12'h018, 32'h0);
        apb(1, `DPG_OFS_MODE, 32'h0);
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            xval <= v[28:24];
            lat = v[20:16];
            oen = v[4:0];
            ien = v[12:8] & 5'h1b;
            apb(1, `DPG_OFS_DATA, {19'h0, lat, 8'h0});
            apb(1, `DPG_OFS_IOEN, {19'h0, v[12:8], 3'h0, oen});
            apb(0, `DPG_OFS_IOEN, {19'h0, ien, 3'h0, oen});
            chk({27'h0, oen}, {27'h0, poe});
            chk({27'h0, lat & oen}, {27'h0, pout & oen});
            ex = {19'h0, lat, 3'h0, ((oen & lat) | (~oen & v[28:24])) & ien};
            apb(0, `DPG_OFS_DATA, ex);
        end
        xval <= 5'h09;
        osc_o <= 1'b1;
        osc_oe <= 1'b1;
        apb(1, `DPG_OFS_MODE, 32'h1f);
        apb(1, `DPG_OFS_FUNC, 32'h280);
        chk(32'h3, {30'h0, osci, dst});
        chk(32'h3, {30'h0, poe[4], pout[4]});
        apb(0, `DPG_OFS_DATA, {19'h0, lat, 8'h0});
        xval <= 5'h00;
        @(posedge clk);
        chk(32'h0, {30'h0, osci, dst});
        tally_and_finish();
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
